// *** bench/cbt_far_model.sv ***
// Far-side model that sends valid host and chain frames as one-cycle pulses.
// Assumes the bench raises run; frames then repeat every gap plus one cycles.
`default_nettype none

module cbt_far_model (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst,
  // Frame request.
  input wire logic run,
  input wire logic [3:0] gap,
  // Frame events.
  output var cbt_pkg::cbt_frame_t frame_ok
);
  timeunit 1ns;
  timeprecision 1ns;
  import cbt_pkg::*;
  logic [3:0] cnt;
  logic side;

  // Host and chain frames alternate so that both sources restart the timers.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst || !run) begin
      cnt <= 4'h0;
      side <= 1'b0;
      frame_ok <= '0;
    end else if (cnt == 4'h0) begin
      cnt <= gap;
      side <= ~side;
      frame_ok <= {side, ~side};
    end else begin
      cnt <= cnt - 4'h1;
      frame_ok <= '0;
    end
  end
endmodule

`default_nettype wire

// *** bench/tb_top.sv ***
// Self-checking bench for cbt_core: registers, direction change, timers, debug.
// Assumes cbt_pkg and cbt_far_model are compiled before it.
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import cbt_pkg::*;
  typedef struct packed {
    logic w;
    logic [13:0] idx;
    logic [31:0] wd;
    logic [31:0] rd;
    logic err;
  } cbt_row_t;
  logic mclk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, run = 0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, wake, dir, busy, fault, sleep_req, shut_req, dbg_on;
  cbt_pwr_t pwr = CBT_ACTIVE;
  cbt_frame_t frame_ok;
  cbt_dbg_t dbg;
  int n_fail = 0, n_tests = 0, n_wake = 0, n_busy = 0, n_sleep = 0, n_shut = 0, t;
  cbt_row_t rows [20] = '{
    '{1'b0, 14'h0010, 32'h0, 32'h0, 1'b0}, '{1'b0, 14'h0011, 32'h0, 32'h0, 1'b0},
    '{1'b0, 14'h0012, 32'h0, 32'h0, 1'b0}, '{1'b0, 14'h0013, 32'h0, 32'h0, 1'b0},
    '{1'b0, 14'h2001, 32'h0, 32'h14, 1'b0}, '{1'b0, 14'h0021, 32'h0, 32'h0f, 1'b0},
    '{1'b1, 14'h0021, 32'h33, 32'h0, 1'b0}, '{1'b0, 14'h0021, 32'h0, 32'h0f, 1'b0},
    '{1'b0, 14'h0022, 32'h0, 32'h5a, 1'b0}, '{1'b0, 14'h0030, 32'h0, 32'h0, 1'b1},
    '{1'b1, 14'h0030, 32'hff, 32'h0, 1'b1}, '{1'b1, 14'h0011, 32'h2, 32'h0, 1'b0},
    '{1'b0, 14'h0011, 32'h0, 32'h2, 1'b0}, '{1'b1, 14'h0012, 32'h3, 32'h0, 1'b0},
    '{1'b0, 14'h0012, 32'h0, 32'h3, 1'b0}, '{1'b0, 14'h0020, 32'h0, 32'h0, 1'b0},
    '{1'b1, 14'h0020, 32'ha5, 32'h0, 1'b0}, '{1'b0, 14'h0020, 32'h0, 32'h1, 1'b0},
    '{1'b1, 14'h0021, 32'h33, 32'h0, 1'b0}, '{1'b0, 14'h0021, 32'h0, 32'h33, 1'b0}};

  always #5 mclk = ~mclk;

  // Counts the cycles in which SEND_WAKE, RECONF_BUSY, SLEEP_REQ and SHUTDOWN_REQ are high.
  always @(negedge mclk) begin
    n_wake += (wake === 1'b1);
    n_busy += (busy === 1'b1);
    n_sleep += (sleep_req === 1'b1);
    n_shut += (shut_req === 1'b1);
  end

  cbt_core #(.TICK_CYCLES(4), .RECONF_CYCLES(8)) cbt_core_inst (
    .MCLK(mclk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .PWR_MODE(pwr), .FRAME_OK(frame_ok), .LINK_STAT(8'h5a), .SEND_WAKE(wake),
    .DIR_SEL(dir), .RECONF_BUSY(busy), .COMM_FAULT(fault), .SLEEP_REQ(sleep_req),
    .SHUTDOWN_REQ(shut_req), .DEBUG_ACTIVE(dbg_on), .DBG_CTRL(dbg));

  cbt_far_model cbt_far_model_inst (.mclk(mclk), .rst(rst), .run(run), .gap(4'h5), .frame_ok(frame_ok));

  task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", name, exp, got);
      n_fail++;
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic apb(input logic w, input logic [13:0] idx, input logic [31:0] wd);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    // Values read right after an edge are the ones sampled at that edge.
    @(posedge mclk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge mclk);
    end
    if (n >= 20) n_fail++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic frame();
    @(posedge mclk);
    run <= 1'b1;
    @(posedge mclk);
    run <= 1'b0;
  endtask

  task automatic wait_fault();
    t = 0;
    while (fault !== 1'b1 && t < 40) begin
      @(posedge mclk);
      t++;
    end
  endtask

  task automatic chk_rst();
    chk("rst_out", {wake, dir, busy, fault, sleep_req, shut_req, dbg_on}, 32'h0);
    chk("rst_dbg", dbg, 32'h0f);
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    cyc(6);
    rst <= 1'b0;
    cyc(1);
    chk_rst();
    for (int i = 0; i < 20; i++) begin
      apb(rows[i].w, rows[i].idx, rows[i].wd);
      chk("rdata", rd, rows[i].rd);
      chk("slverr", err, rows[i].err);
    end
    chk("dbg_port", {dbg_on, dbg}, 32'h133);
    apb(1'b1, 14'h0020, 32'h0);
    cyc(2);
    chk("dbg_exit", {dbg_on, dbg}, 32'h00f);
    n_wake = 0;
    n_busy = 0;
    apb(1'b1, 14'h0010, 32'h21);
    cyc(20);
    chk("wake_pulses", n_wake, 1);
    chk("busy_cycles", n_busy, 8);
    apb(1'b0, 14'h0010, 32'h0);
    chk("ctrl", {dir, rd[30:0]}, 32'h80000020);
    apb(1'b1, 14'h0010, 32'h0);
    cyc(20);
    chk("busy_back", {dir, n_busy[30:0]}, 16);
    pwr <= CBT_SHUTDOWN;
    apb(1'b1, 14'h0013, 32'h3);
    n_sleep = 0;
    cyc(40);
    chk("shutdown_idle", {fault, n_sleep[30:0]}, 0);
    pwr <= CBT_ACTIVE;
    run <= 1'b1;
    cyc(60);
    run <= 1'b0;
    chk("keep_alive", {fault, n_sleep[30:0]}, 0);
    frame();
    wait_fault();
    chk("short_time", (t >= 9 && t <= 13), 1);
    cyc(30);
    chk("long_sleep", {n_shut[15:0], n_sleep[15:0]}, 1);
    run <= 1'b1;
    apb(1'b1, 14'h0013, 32'h3);
    cyc(1);
    chk("fault_clear", fault, 0);
    run <= 1'b0;
    frame();
    cyc(6);
    pwr <= CBT_SLEEP;
    cyc(50);
    chk("sleep_frozen", fault, 0);
    pwr <= CBT_ACTIVE;
    wait_fault();
    chk("resume_time", (t >= 1 && t <= 7), 1);
    run <= 1'b1;
    apb(1'b1, 14'h0012, 32'h10003);
    n_sleep = 0;
    n_shut = 0;
    run <= 1'b0;
    frame();
    cyc(30);
    chk("long_shut", {n_sleep[15:0], n_shut[15:0]}, 1);
    rst <= 1'b1;
    cyc(2);
    rst <= 1'b0;
    cyc(1);
    chk_rst();
    apb(1'b0, 14'h0011, 32'h0);
    chk("short_rst", rd, 32'h0);
    give_verdict();
  end

  initial begin
    cyc(5000);
    n_fail++;
    give_verdict();
  end
endmodule

`default_nettype wire

// *** hw/cbt_core.sv ***
// Bridge chain control, two communication timeout supervisors and debug access behind APB.
// Assumes power mode and frame-valid pulses come from logic on MCLK; link status likewise.
`include "cbt_map.svh"
`default_nettype none

// Contract
// - Bridge register 0x2001 reads 0x14 after initialisation.
// - Active device runs short and long timers; short flags, long requests sleep or shutdown.
// - Timers measure time without a valid host or chain frame.
// - Shutdown clears both timers; sleep freezes their counts.
// - Any valid command or response frame restarts counting.
// - Debug unlock gates baud and port controls; link status always readable.
module cbt_core #(
  parameter int unsigned TICK_CYCLES = `CBT_TICK_CYCLES,
  parameter int unsigned RECONF_CYCLES = `CBT_RECONF_CYCLES
) (
  // Clock and reset.
  input wire logic MCLK,
  input wire logic RST,
  // APB slave.
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [15:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Power mode, frame events and link status.
  input wire cbt_pkg::cbt_pwr_t PWR_MODE,
  input wire cbt_pkg::cbt_frame_t FRAME_OK,
  input wire logic [7:0] LINK_STAT,
  // Chain controls and supervisor outputs.
  output logic SEND_WAKE,
  output logic DIR_SEL,
  output logic RECONF_BUSY,
  output logic COMM_FAULT,
  output logic SLEEP_REQ,
  output logic SHUTDOWN_REQ,
  // Debug controls.
  output logic DEBUG_ACTIVE,
  output cbt_pkg::cbt_dbg_t DBG_CTRL
);
  import cbt_pkg::*;

  // ****************************************
  // Bus decode
  // ****************************************
  logic [13:0] idx;
  logic acc;
  logic wr;
  logic mapped;
  logic [31:0] next_rdata;
  logic [15:0] short_period;
  logic [16:0] long_cfg;
  logic long_expired;
  logic [7:0] dbg_reg;
  logic [16:0] presc;
  logic [15:0] cnt [2];
  logic [1:0] fired;
  logic [1:0] fire;
  logic [13:0] reconf_cnt;
  logic frame_any;
  logic tick;

  assign idx = PADDR[15:2];
  assign acc = PSEL && PENABLE && PREADY;
  assign wr = acc && PWRITE;
  assign frame_any = FRAME_OK.host_ok || FRAME_OK.chain_ok;

  always_comb begin
    mapped = 1'b1;
    next_rdata = 32'h0000_0000;
    case (idx)
      `CBT_IDX_CTRL: next_rdata[`CBT_CTRL_DIR_SEL] = DIR_SEL;
      `CBT_IDX_TO_SHORT: next_rdata[15:0] = short_period;
      `CBT_IDX_TO_LONG: next_rdata[16:0] = long_cfg;
      `CBT_IDX_TO_STAT: begin
        next_rdata[`CBT_STAT_SHORT] = COMM_FAULT;
        next_rdata[`CBT_STAT_LONG] = long_expired;
        next_rdata[2] = RECONF_BUSY;
      end
      `CBT_IDX_DBG_UNLOCK: next_rdata[0] = DEBUG_ACTIVE;
      `CBT_IDX_DBG_CTRL: next_rdata[7:0] = dbg_reg;
      `CBT_IDX_DBG_STAT: next_rdata[7:0] = LINK_STAT;
      `CBT_IDX_INIT_CHECK: next_rdata = `CBT_INIT_CHECK_VAL;
      default: mapped = 1'b0;
    endcase
  end

  // Answer in the second access cycle with registered data.
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      PREADY <= 1'b0;
      PRDATA <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= PSEL && PENABLE && !PREADY;
      if (PSEL && PENABLE && !PREADY) begin
        PRDATA <= PWRITE ? 32'h0000_0000 : next_rdata;
        PSLVERR <= !mapped;
      end else begin
        PSLVERR <= 1'b0;
      end
    end
  end

  // ****************************************
  // Chain control
  // ****************************************
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      SEND_WAKE <= 1'b0;
      DIR_SEL <= 1'b0;
      RECONF_BUSY <= 1'b0;
      reconf_cnt <= 14'h0000;
    end else begin
      SEND_WAKE <= wr && idx == `CBT_IDX_CTRL && PWDATA[`CBT_CTRL_SEND_WAKE];
      if (wr && idx == `CBT_IDX_CTRL) begin
        DIR_SEL <= PWDATA[`CBT_CTRL_DIR_SEL];
      end
      // A direction change holds the busy bit while the ports reconfigure.
      if (wr && idx == `CBT_IDX_CTRL && PWDATA[`CBT_CTRL_DIR_SEL] != DIR_SEL) begin
        reconf_cnt <= 14'(RECONF_CYCLES);
        RECONF_BUSY <= 1'b1;
      end else if (reconf_cnt != 14'h0000) begin
        reconf_cnt <= reconf_cnt - 14'h0001;
        RECONF_BUSY <= reconf_cnt != 14'h0001;
      end
    end
  end

  // ****************************************
  // Timeout configuration
  // ****************************************
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      short_period <= `CBT_TO_SHORT_RST;
      long_cfg <= `CBT_TO_LONG_RST;
    end else if (wr && idx == `CBT_IDX_TO_SHORT) begin
      short_period <= PWDATA[15:0];
    end else if (wr && idx == `CBT_IDX_TO_LONG) begin
      long_cfg <= PWDATA[16:0];
    end
  end

  // ****************************************
  // Timeout supervisors
  // ****************************************
  assign tick = PWR_MODE == CBT_ACTIVE && presc == 17'(TICK_CYCLES - 1);

  // The prescaler freezes in sleep so a sleeping count resumes in phase; shutdown clears it.
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      presc <= 17'h00000;
    end else if (PWR_MODE == CBT_SHUTDOWN || frame_any) begin
      presc <= 17'h00000;
    end else if (PWR_MODE == CBT_ACTIVE) begin
      presc <= tick ? 17'h00000 : presc + 17'h00001;
    end
  end

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      fire[i] = tick && !fired[i] && !frame_any && (i == 0 ? short_period : long_cfg[15:0]) != 16'h0000 &&
                cnt[i] + 16'h0001 >= (i == 0 ? short_period : long_cfg[15:0]);
    end
  end

  // A zero period disables that supervisor; an expired one stays put until a frame arrives or shutdown clears it.
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      cnt[0] <= 16'h0000;
      cnt[1] <= 16'h0000;
      fired <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (PWR_MODE == CBT_SHUTDOWN || frame_any) begin
          cnt[i] <= 16'h0000;
          fired[i] <= 1'b0;
        end else if (fire[i]) begin
          fired[i] <= 1'b1;
        end else if (tick && !fired[i]) begin
          cnt[i] <= cnt[i] + 16'h0001;
        end
      end
    end
  end

  // Expiry flags are write-one-to-clear; a new expiry wins over a clear.
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      COMM_FAULT <= 1'b0;
      long_expired <= 1'b0;
      SLEEP_REQ <= 1'b0;
      SHUTDOWN_REQ <= 1'b0;
    end else begin
      if (fire[0]) begin
        COMM_FAULT <= 1'b1;
      end else if (wr && idx == `CBT_IDX_TO_STAT && PWDATA[`CBT_STAT_SHORT]) begin
        COMM_FAULT <= 1'b0;
      end
      if (fire[1]) begin
        long_expired <= 1'b1;
      end else if (wr && idx == `CBT_IDX_TO_STAT && PWDATA[`CBT_STAT_LONG]) begin
        long_expired <= 1'b0;
      end
      SLEEP_REQ <= fire[1] && !long_cfg[`CBT_LONG_ACTION];
      SHUTDOWN_REQ <= fire[1] && long_cfg[`CBT_LONG_ACTION];
    end
  end

  // ****************************************
  // Debug access
  // ****************************************
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      DEBUG_ACTIVE <= 1'b0;
      dbg_reg <= `CBT_DBG_CTRL_RST;
      DBG_CTRL <= cbt_dbg_t'(`CBT_DBG_CTRL_RST);
    end else begin
      if (wr && idx == `CBT_IDX_DBG_UNLOCK) begin
        DEBUG_ACTIVE <= PWDATA[7:0] == `CBT_DBG_KEY;
      end
      if (wr && idx == `CBT_IDX_DBG_CTRL && DEBUG_ACTIVE) begin
        dbg_reg <= PWDATA[7:0];
      end
      DBG_CTRL <= DEBUG_ACTIVE ? cbt_dbg_t'(dbg_reg) : cbt_dbg_t'(`CBT_DBG_CTRL_RST);
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  property p_init_check;
    @(posedge MCLK) disable iff (RST)
    PSEL && PENABLE && PREADY && !PWRITE && idx == `CBT_IDX_INIT_CHECK |-> PRDATA == 32'h0000_0014;
  endproperty
  a_init_check: assert property (p_init_check) else $error("init check register not 0x14");

  property p_short_flag;
    @(posedge MCLK) disable iff (RST)
    fire[0] |=> COMM_FAULT && fired[0];
  endproperty
  a_short_flag: assert property (p_short_flag) else $error("short expiry did not flag fault");

  property p_long_req;
    @(posedge MCLK) disable iff (RST)
    fire[1] |=> (SLEEP_REQ ^ SHUTDOWN_REQ) ##1 !SLEEP_REQ && !SHUTDOWN_REQ;
  endproperty
  a_long_req: assert property (p_long_req) else $error("long expiry request not a single pulse");

  property p_chain_frame;
    @(posedge MCLK) disable iff (RST)
    FRAME_OK.chain_ok && !FRAME_OK.host_ok |=> cnt[0] == 16'h0000 && cnt[1] == 16'h0000 && fired == 2'b00;
  endproperty
  a_chain_frame: assert property (p_chain_frame) else $error("chain frame did not restart timers");

  property p_shutdown_clear;
    @(posedge MCLK) disable iff (RST)
    PWR_MODE == CBT_SHUTDOWN |=> cnt[0] == 16'h0000 && cnt[1] == 16'h0000 && presc == 17'h00000;
  endproperty
  a_shutdown_clear: assert property (p_shutdown_clear) else $error("timers not cleared in shutdown");

  property p_sleep_freeze;
    @(posedge MCLK) disable iff (RST)
    PWR_MODE == CBT_SLEEP && !frame_any |=> $stable(cnt[0]) && $stable(cnt[1]) && $stable(presc);
  endproperty
  a_sleep_freeze: assert property (p_sleep_freeze) else $error("timers moved in sleep");

  property p_host_frame;
    @(posedge MCLK) disable iff (RST)
    FRAME_OK.host_ok |=> presc == 17'h00000 && cnt[0] == 16'h0000 && !SLEEP_REQ && !SHUTDOWN_REQ;
  endproperty
  a_host_frame: assert property (p_host_frame) else $error("host frame did not restart timers");

  property p_debug_lock;
    @(posedge MCLK) disable iff (RST)
    !DEBUG_ACTIVE ##1 !DEBUG_ACTIVE |-> DBG_CTRL == cbt_dbg_t'(`CBT_DBG_CTRL_RST);
  endproperty
  a_debug_lock: assert property (p_debug_lock) else $error("debug controls moved while locked");
endmodule

`default_nettype wire

// *** hw/cbt_map.svh ***
// Offsets, field positions, reset values and timing counts of the chain bring-up block.
// Assumes a 100 MHz core clock and APB word addressing (byte address is four times the index).
`ifndef CBT_MAP_SVH
`define CBT_MAP_SVH

// ****************************************
// Register indices
// ****************************************
`define CBT_IDX_CTRL 14'h0010
`define CBT_IDX_TO_SHORT 14'h0011
`define CBT_IDX_TO_LONG 14'h0012
`define CBT_IDX_TO_STAT 14'h0013
`define CBT_IDX_DBG_UNLOCK 14'h0020
`define CBT_IDX_DBG_CTRL 14'h0021
`define CBT_IDX_DBG_STAT 14'h0022
`define CBT_IDX_INIT_CHECK 14'h2001

// ****************************************
// Field positions
// ****************************************
`define CBT_CTRL_SEND_WAKE 0
`define CBT_CTRL_DIR_SEL 5
`define CBT_LONG_ACTION 16
`define CBT_STAT_SHORT 0
`define CBT_STAT_LONG 1

// ****************************************
// Values and reset values
// ****************************************
`define CBT_INIT_CHECK_VAL 32'h0000_0014
`define CBT_DBG_KEY 8'ha5
`define CBT_TO_SHORT_RST 16'h0000
`define CBT_TO_LONG_RST 17'h00000
`define CBT_DBG_CTRL_RST 8'h0f

// ****************************************
// Timing
// ****************************************
`define CBT_CLK_MHZ 100
`define CBT_RECONF_TIME_US 100
`define CBT_RECONF_CYCLES (`CBT_RECONF_TIME_US * `CBT_CLK_MHZ)
`define CBT_TICK_TIME_US 1000
`define CBT_TICK_CYCLES (`CBT_TICK_TIME_US * `CBT_CLK_MHZ)

`endif

// *** hw/cbt_pkg.sv ***
// Types shared by the chain bring-up and timeout block.
// Assumes nothing of its surroundings.
`default_nettype none

package cbt_pkg;
  typedef enum logic [1:0] {
    CBT_ACTIVE = 2'h0,
    CBT_SLEEP = 2'h1,
    CBT_SHUTDOWN = 2'h3
  } cbt_pwr_t;

  typedef struct packed {
    logic host_ok;
    logic chain_ok;
  } cbt_frame_t;

  typedef struct packed {
    logic [1:0] host_baud;
    logic [1:0] chain_baud;
    logic north_tx;
    logic north_rx;
    logic south_tx;
    logic south_rx;
  } cbt_dbg_t;
endpackage

`default_nettype wire
